// [rtl/cmrm_consts.svh]
// constants of the core address map and decode block
`ifndef CMRM_CONSTS_SVH
`define CMRM_CONSTS_SVH
`define CMRM_RESET_VEC 14'h0000
`define CMRM_SUPPLY_VEC 14'h0004
`define CMRM_DBLK_VEC0 14'h0008
`define CMRM_DBLK_VEC7 14'h0024
`define CMRM_ACOL_VEC0 14'h0028
`define CMRM_ACOL_VEC3 14'h0034
`define CMRM_GPIO_VEC 14'h0038
`define CMRM_SLEEP_VEC 14'h003c
`define CMRM_USER_START 14'h0040
`define CMRM_PROG_MAX 14'h3fff
`define CMRM_STACK_BASE 8'h00
`define CMRM_PAGE_TOP 8'hff
`define CMRM_SHARED_LO 8'h71
`define CMRM_SHARED_HI 8'h9f
`define CMRM_OP_OR_IDX 8'h44
`define CMRM_OP_XOR_IDX 8'h46
`define CMRM_IDX_OP_LEN 2'h3
`define CMRM_IDX_OP_CYC 4'ha
`endif

// [rtl/cmrm_pkg.sv]
// types of the core address map and decode block
`default_nettype none
package cmrm_pkg;
  typedef enum logic [2:0] {
    CMRM_IDLE = 3'b001,
    CMRM_EXEC = 3'b010,
    CMRM_VECT = 3'b100
  } cmrm_state_t;
  typedef enum logic [1:0] {
    CMRM_ALU_NONE = 2'h0,
    CMRM_ALU_OR = 2'h1,
    CMRM_ALU_XOR = 2'h2
  } cmrm_alu_t;
endpackage : cmrm_pkg
`default_nettype wire

// [rtl/cmrm_irq_vec.sv]
// interrupt priority encoder giving the vector address
`default_nettype none
`include "cmrm_consts.svh"
module cmrm_irq_vec (
  input wire logic supply_irq,
  input wire logic [7:0] dblk_irq,
  input wire logic [3:0] acol_irq,
  input wire logic gpio_irq,
  input wire logic sleep_irq,
  output logic any_irq,
  output logic [13:0] vec_addr
);
  // lowest vector slot wins, matching table order
  always_comb begin
    any_irq = 1'b1;
    vec_addr = `CMRM_RESET_VEC;
    if (supply_irq) begin
      vec_addr = `CMRM_SUPPLY_VEC;
    end else if (|dblk_irq) begin
      vec_addr = `CMRM_DBLK_VEC0;
      for (int i = 7; i >= 0; i--) begin
        if (dblk_irq[i]) begin
          vec_addr = `CMRM_DBLK_VEC0 + 14'(4 * i);
        end
      end
    end else if (|acol_irq) begin
      vec_addr = `CMRM_ACOL_VEC0;
      for (int j = 3; j >= 0; j--) begin
        if (acol_irq[j]) begin
          vec_addr = `CMRM_ACOL_VEC0 + 14'(4 * j);
        end
      end
    end else if (gpio_irq) begin
      vec_addr = `CMRM_GPIO_VEC;
    end else if (sleep_irq) begin
      vec_addr = `CMRM_SLEEP_VEC;
    end else begin
      any_irq = 1'b0;
    end
  end
endmodule : cmrm_irq_vec
`default_nettype wire

// [rtl/cmrm_core_map.sv]
// fetch sequencer, vectoring, stack and banked register decode
//
// How it works
// - supply monitor interrupt vectors to 0x0004
// - digital blocks 0..7 vector to 0x0008..0x0024 in order
// - analog columns 0..3 vector to 0x0028..0x0034 in order
// - pin interrupt vectors to 0x0038
// - sleep timer interrupt vectors to 0x003c
// - user code begins at 0x0040
// - program counter wraps within 0x3fff
// - stack starts at data address zero and grows upward
// - data page addresses are eight bits, up to 0xff
// - two register banks of 256 addresses each
// - bank chosen by the bank_select_flag bit
// - addresses 71h..9fh map the same in both banks
// - opcode 46 is xor immediate into reg[x+off], 3 bytes, 10 cycles
// - opcode 44 is or immediate into reg[x+off], 3 bytes, 10 cycles
`default_nettype none
`include "cmrm_consts.svh"
module cmrm_core_map (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply_irq,
  input wire logic [7:0] dblk_irq,
  input wire logic [3:0] acol_irq,
  input wire logic gpio_irq,
  input wire logic sleep_irq,
  input wire logic irq_enable,
  input wire logic [7:0] fetch_data,
  input wire logic fetch_valid,
  input wire logic bank_select_flag,
  input wire logic [7:0] x_index,
  input wire logic stack_push,
  input wire logic stack_pop,
  output logic [13:0] pc,
  output logic [7:0] sp,
  output logic vector_taken,
  output logic [8:0] reg_addr,
  output logic reg_wr,
  output logic [1:0] alu_op,
  output logic [7:0] reg_imm,
  output logic in_user_space
);
  cmrm_pkg::cmrm_state_t state_reg;
  logic [13:0] pc_reg;
  logic [7:0] sp_reg;
  logic [1:0] byte_cnt_reg;
  logic [3:0] cyc_cnt_reg;
  logic [7:0] opcode_reg;
  logic [7:0] offset_reg;
  logic [7:0] imm_reg;
  logic vec_reg;
  logic [8:0] raddr_reg;
  logic wr_reg;
  logic [1:0] alu_reg;
  logic [7:0] imm_out_reg;
  logic user_reg;
  logic any_irq;
  logic [13:0] vec_addr;
  logic op_is_idx;

  // sync of pin-side interrupt inputs; stage one is only read by stage two
  logic [14:0] irq_s1_reg;
  logic [14:0] irq_s2_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_s1_reg <= 15'h0000;
      irq_s2_reg <= 15'h0000;
    end else begin
      irq_s1_reg <= {supply_irq, dblk_irq, acol_irq, gpio_irq, sleep_irq};
      irq_s2_reg <= irq_s1_reg;
    end
  end

  cmrm_irq_vec u_vec (
    .supply_irq(irq_s2_reg[14]),
    .dblk_irq(irq_s2_reg[13:6]),
    .acol_irq(irq_s2_reg[5:2]),
    .gpio_irq(irq_s2_reg[1]),
    .sleep_irq(irq_s2_reg[0]),
    .any_irq(any_irq),
    .vec_addr(vec_addr)
  );

  // bank bit forms address bit 8; shared window folds to bank 0
  function automatic logic [8:0] bank_map(input logic bank,
                                          input logic [7:0] addr);
    if (addr >= `CMRM_SHARED_LO && addr <= `CMRM_SHARED_HI) begin
      bank_map = {1'b0, addr};
    end else begin
      bank_map = {bank, addr};
    end
  endfunction : bank_map

  function automatic logic is_idx_op(input logic [7:0] op);
    is_idx_op = (op == `CMRM_OP_XOR_IDX) || (op == `CMRM_OP_OR_IDX);
  endfunction : is_idx_op

  assign op_is_idx = is_idx_op(fetch_data);

  // sequencer: vector between instructions, run indexed ops to length
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= cmrm_pkg::CMRM_IDLE;
      pc_reg <= `CMRM_RESET_VEC;
      byte_cnt_reg <= 2'h0;
      cyc_cnt_reg <= 4'h0;
      opcode_reg <= 8'h00;
      offset_reg <= 8'h00;
      imm_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        cmrm_pkg::CMRM_IDLE: begin
          if (irq_enable && any_irq) begin
            state_reg <= cmrm_pkg::CMRM_VECT;
          end else if (fetch_valid) begin
            pc_reg <= pc_reg + 14'h0001;
            if (op_is_idx) begin
              opcode_reg <= fetch_data;
              byte_cnt_reg <= 2'h1;
              cyc_cnt_reg <= 4'h1;
              state_reg <= cmrm_pkg::CMRM_EXEC;
            end
          end
        end
        cmrm_pkg::CMRM_EXEC: begin
          if (cyc_cnt_reg != 4'hf) begin
            cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
          end
          if (fetch_valid && byte_cnt_reg != `CMRM_IDX_OP_LEN) begin
            pc_reg <= pc_reg + 14'h0001;
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            if (byte_cnt_reg == 2'h1) begin
              offset_reg <= fetch_data;
            end else begin
              imm_reg <= fetch_data;
            end
          end
          // ten cycles from opcode fetch to write
          if (cyc_cnt_reg >= `CMRM_IDX_OP_CYC - 4'h1 &&
              byte_cnt_reg == `CMRM_IDX_OP_LEN) begin
            state_reg <= cmrm_pkg::CMRM_IDLE;
          end
        end
        cmrm_pkg::CMRM_VECT: begin
          pc_reg <= vec_addr;
          state_reg <= cmrm_pkg::CMRM_IDLE;
        end
        default: begin
          state_reg <= cmrm_pkg::CMRM_IDLE;
        end
      endcase
    end
  end

  logic op_done;
  assign op_done = state_reg == cmrm_pkg::CMRM_EXEC &&
                   cyc_cnt_reg >= `CMRM_IDX_OP_CYC - 4'h1 &&
                   byte_cnt_reg == `CMRM_IDX_OP_LEN;

  // register write port of the indexed or/xor ops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= 1'b0;
      raddr_reg <= 9'h000;
      alu_reg <= cmrm_pkg::CMRM_ALU_NONE;
      imm_out_reg <= 8'h00;
    end else begin
      wr_reg <= op_done;
      if (op_done) begin
        // offset wraps within the 256-address bank
        raddr_reg <= bank_map(bank_select_flag,
                              8'(x_index + offset_reg));
        alu_reg <= (opcode_reg == `CMRM_OP_XOR_IDX) ?
                   cmrm_pkg::CMRM_ALU_XOR : cmrm_pkg::CMRM_ALU_OR;
        imm_out_reg <= imm_reg;
      end
    end
  end

  // stack pointer: grows upward, 8-bit page so wraps at the page top
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sp_reg <= `CMRM_STACK_BASE;
    end else if (stack_push && !stack_pop) begin
      sp_reg <= sp_reg + 8'h01;
    end else if (stack_pop && !stack_push) begin
      sp_reg <= sp_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vec_reg <= 1'b0;
      user_reg <= 1'b0;
    end else begin
      vec_reg <= state_reg == cmrm_pkg::CMRM_VECT;
      user_reg <= pc_reg >= `CMRM_USER_START;
    end
  end

  assign pc = pc_reg;
  assign sp = sp_reg;
  assign vector_taken = vec_reg;
  assign reg_addr = raddr_reg;
  assign reg_wr = wr_reg;
  assign alu_op = alu_reg;
  assign reg_imm = imm_out_reg;
  assign in_user_space = user_reg;

  // checks
  sequence s_vect;
    state_reg == cmrm_pkg::CMRM_VECT;
  endsequence
  property p_vec_load;
    @(posedge clk) disable iff (!nrst)
      s_vect |=> pc_reg == $past(vec_addr) && vector_taken;
  endproperty
  a_vec_load: assert property (p_vec_load)
    else $error("vector not loaded");
  property p_vec_range;
    @(posedge clk) disable iff (!nrst)
      vector_taken |-> pc_reg[1:0] == 2'h0 && pc_reg <= `CMRM_SLEEP_VEC;
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("vector out of table");
  property p_supply_first;
    @(posedge clk) disable iff (!nrst)
      s_vect ##0 irq_s2_reg[14] |=> pc_reg == `CMRM_SUPPLY_VEC;
  endproperty
  a_supply_first: assert property (p_supply_first)
    else $error("supply vector wrong");
  property p_sleep;
    @(posedge clk) disable iff (!nrst)
      s_vect ##0 irq_s2_reg == 15'h0001 |=> pc_reg == `CMRM_SLEEP_VEC;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep vector wrong");
  property p_gpio;
    @(posedge clk) disable iff (!nrst)
      s_vect ##0 irq_s2_reg[14:1] == 14'h0001 |=> pc_reg == `CMRM_GPIO_VEC;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("pin vector wrong");
  property p_shared;
    @(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr[7:0] >= `CMRM_SHARED_LO &&
      reg_addr[7:0] <= `CMRM_SHARED_HI |-> !reg_addr[8];
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared window banked");
  // opcode taken: idle, then exec on the next edge
  sequence s_op_start;
    state_reg == cmrm_pkg::CMRM_IDLE ##1
    state_reg == cmrm_pkg::CMRM_EXEC;
  endsequence
  property p_op_len;
    @(posedge clk) disable iff (!nrst)
      s_op_start |-> ##[9:300] reg_wr;
  endproperty
  a_op_len: assert property (p_op_len)
    else $error("indexed op too short");
  property p_wr_pulse;
    @(posedge clk) disable iff (!nrst)
      reg_wr |=> !reg_wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write not single pulse");
  property p_stack;
    @(posedge clk) disable iff (!nrst)
      stack_push && !stack_pop |=> sp_reg == 8'($past(sp_reg) + 8'h01);
  endproperty
  a_stack: assert property (p_stack)
    else $error("stack not growing up");
  property p_reset_vec;
    @(posedge clk) $rose(nrst) |-> pc_reg == `CMRM_RESET_VEC;
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("fetch not from reset vector");
  property p_dblk;
    @(posedge clk) disable iff (!nrst)
      s_vect ##0 !irq_s2_reg[14] && irq_s2_reg[13:6] != 8'h00 |=>
      pc_reg >= `CMRM_DBLK_VEC0 && pc_reg <= `CMRM_DBLK_VEC7;
  endproperty
  a_dblk: assert property (p_dblk)
    else $error("digital block vector wrong");
  property p_acol;
    @(posedge clk) disable iff (!nrst)
      s_vect ##0 irq_s2_reg[14:6] == 9'h000 && irq_s2_reg[5:2] != 4'h0 |=>
      pc_reg >= `CMRM_ACOL_VEC0 && pc_reg <= `CMRM_ACOL_VEC3;
  endproperty
  a_acol: assert property (p_acol)
    else $error("analog column vector wrong");
  property p_user;
    @(posedge clk) disable iff (!nrst)
      in_user_space |-> $past(pc_reg) >= `CMRM_USER_START;
  endproperty
  a_user: assert property (p_user)
    else $error("user space flag wrong");
  property p_xor_kind;
    @(posedge clk) disable iff (!nrst)
      op_done && opcode_reg == `CMRM_OP_XOR_IDX |=>
      alu_op == cmrm_pkg::CMRM_ALU_XOR;
  endproperty
  a_xor_kind: assert property (p_xor_kind)
    else $error("xor op decoded wrong");
  property p_or_kind;
    @(posedge clk) disable iff (!nrst)
      op_done && opcode_reg == `CMRM_OP_OR_IDX |=>
      alu_op == cmrm_pkg::CMRM_ALU_OR;
  endproperty
  a_or_kind: assert property (p_or_kind)
    else $error("or op decoded wrong");
endmodule : cmrm_core_map
`default_nettype wire

// [tb/cmrm_core_map_tb.sv]
// self-checking bench of the core address map and decode block
`default_nettype none
`include "cmrm_consts.svh"
module cmrm_core_map_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, supply_irq, gpio_irq, sleep_irq, irq_enable;
  logic fetch_valid, bank_select_flag, stack_push, stack_pop;
  logic [7:0] dblk_irq, fetch_data, x_index, sp, reg_imm;
  logic [3:0] acol_irq;
  logic [13:0] pc;
  logic [8:0] reg_addr;
  logic [1:0] alu_op;
  logic vector_taken, reg_wr, in_user_space;
  logic [18:0] exp_q[$];
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int t_op = 0;
  cmrm_core_map uut (.clk(clk), .nrst(nrst), .supply_irq(supply_irq),
    .dblk_irq(dblk_irq), .acol_irq(acol_irq), .gpio_irq(gpio_irq),
    .sleep_irq(sleep_irq), .irq_enable(irq_enable),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid),
    .bank_select_flag(bank_select_flag), .x_index(x_index),
    .stack_push(stack_push), .stack_pop(stack_pop), .pc(pc), .sp(sp),
    .vector_taken(vector_taken), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .alu_op(alu_op), .reg_imm(reg_imm), .in_user_space(in_user_space));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  // results still owed after the wait are lost, not late
  task automatic drain;
    int t;
    t = 0;
    while (exp_q.size() != 0 && t < 40) begin
      step(1);
      t++;
    end
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("[FAIL] %0t result missing", $time);
      exp_q.delete();
    end
  endtask : drain
  // source k: 0 supply, 1..8 digital, 9..12 analog, 13 pin, 14 sleep
  task automatic raise(input int k);
    int t;
    exp_q.push_back(19'(4 * (k + 1)));
    irq_enable = 1'b1;
    supply_irq = (k == 0);
    dblk_irq = (k >= 1 && k <= 8) ? 8'(1 << (k - 1)) : 8'h00;
    acol_irq = (k >= 9 && k <= 12) ? 4'(1 << (k - 9)) : 4'h0;
    gpio_irq = (k == 13);
    sleep_irq = (k == 14);
    t = 0;
    do begin
      step(1);
      t++;
    end while (vector_taken !== 1'b1 && t < 30);
    // enable drops first so a still-synced request cannot vector again
    {supply_irq, gpio_irq, sleep_irq, irq_enable} = 4'h0;
    dblk_irq = 8'h00;
    acol_irq = 4'h0;
    step(4);
    drain();
  endtask : raise
  task automatic run_op(input logic [7:0] op, input logic [7:0] off,
      input logic [7:0] imm);
    logic [7:0] a;
    logic b;
    a = x_index + off;
    b = (a >= `CMRM_SHARED_LO && a <= `CMRM_SHARED_HI) ? 1'b0 :
      bank_select_flag;
    exp_q.push_back({(op == `CMRM_OP_XOR_IDX) ? 2'h2 : 2'h1, b, a, imm});
    t_op = cycles;
    fetch_valid = 1'b1;
    fetch_data = op;
    step(1);
    fetch_data = off;
    step(1);
    fetch_data = imm;
    step(1);
    fetch_valid = 1'b0;
    drain();
  endtask : run_op
  always @(negedge clk) begin
    if (vector_taken === 1'b1 || reg_wr === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] %0t unexpected result", $time);
      end else if (vector_taken === 1'b1) begin
        check({5'h00, pc}, exp_q.pop_front());
      end else begin
        check({alu_op, reg_addr, reg_imm}, exp_q.pop_front());
        check(19'(cycles - t_op), 19'(`CMRM_IDX_OP_CYC));
      end
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      $display("[FAIL] %0t run timed out", $time);
      print_verdict();
    end
  end
  initial begin
    logic [7:0] offs[4];
    offs = '{8'h00, 8'h01, 8'h2f, 8'h30};
    {nrst, supply_irq, gpio_irq, sleep_irq, irq_enable} = 5'h00;
    {fetch_valid, bank_select_flag, stack_push, stack_pop} = 4'h0;
    dblk_irq = 8'h00;
    acol_irq = 4'h0;
    fetch_data = 8'h00;
    x_index = 8'h00;
    void'($urandom(58));
    repeat (5) @(posedge clk);
    #2;
    nrst = 1'b1;
    step(1);
    check({5'h00, pc}, {5'h00, `CMRM_RESET_VEC});
    check({11'h000, sp}, {11'h000, `CMRM_STACK_BASE});
    $display("test reset done");
    stack_push = 1'b1;
    step(2);
    stack_push = 1'b0;
    check({11'h000, sp}, 19'h00002);
    stack_pop = 1'b1;
    step(1);
    stack_pop = 1'b0;
    check({11'h000, sp}, 19'h00001);
    $display("test stack done");
    step(3);
    for (int k = 0; k < 15; k++) raise(k);
    check({5'h00, pc}, {5'h00, `CMRM_SLEEP_VEC});
    check({18'h00000, in_user_space}, 19'h00000);
    fetch_data = 8'h40;
    fetch_valid = 1'b1;
    step(4);
    fetch_valid = 1'b0;
    step(2);
    check({5'h00, pc}, {5'h00, `CMRM_USER_START});
    check({18'h00000, in_user_space}, 19'h00001);
    $display("test vectors done");
    for (int i = 0; i < 8; i++) begin
      bank_select_flag = (i < 4) ? (i != 3) : 1'($urandom);
      x_index = (i < 4) ? 8'h70 : 8'($urandom);
      run_op(i[0] ? `CMRM_OP_OR_IDX : `CMRM_OP_XOR_IDX,
        (i < 4) ? offs[i] : 8'($urandom), 8'($urandom));
    end
    $display("test indexed ops done");
    print_verdict();
  end
endmodule : cmrm_core_map_tb
`default_nettype wire
